// *** odb_map.vh ***
// register offsets, field positions, reset values and fixed codes
`ifndef ODB_MAP_VH
`define ODB_MAP_VH
`define ODB_ADDR_STATUS     8'h10
`define ODB_ADDR_CONFIG     8'h11
`define ODB_ADDR_DBCOUNT    8'h12
`define ODB_ADDR_BFZLOCK    8'h13
`define ODB_ADDR_THSHYS     8'h14
`define ODB_CFG_DBMODE_BIT  7
`define ODB_CFG_ENABLE_BIT  6
`define ODB_CFG_RESET       8'h80
`define ODB_DBCOUNT_RESET   8'h00
`define ODB_BFZLOCK_VALUE   8'h44
`define ODB_THSHYS_VALUE    8'h84
`define ODB_TRIP_TO_PORT    7'h3B
`define ODB_TRIP_TO_LAND    7'h1F
`define ODB_ANGLE_A_DEG       7'h1D
`define ODB_BACKFRONT_DEG   7'h4B
`define ODB_OVERG_COUNTS    10'h140
`define ODB_MODE_NORMAL     2'h0
`define ODB_MODE_LNLP       2'h1
`define ODB_MODE_HIRES      2'h2
`define ODB_MODE_LP         2'h3
`define ODB_STEPUS_800      16'h04E2
`endif

// *** odb_time_step.v ***
// counter weight per sample from output data rate and oversampling mode
`timescale 1ns/1ps
`include "odb_map.vh"
module odb_time_step (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire [2:0]  outputDataRate,
	input  wire [1:0]  oversampleMode,
	output reg  [7:0]  stepIncr,
	output reg  [17:0] stepUs
);
	// output_data_rate codes 0..7: 800,400,200,100,50,12.5,6.25,1.56 Hz
	// sample period in units of the 800 Hz step, as a power of two
	function [3:0] periodLog;
		input [2:0] output_data_rate;
		begin
			case (output_data_rate)
			3'h0: periodLog = 4'h0;
			3'h1: periodLog = 4'h1;
			3'h2: periodLog = 4'h2;
			3'h3: periodLog = 4'h3;
			3'h4: periodLog = 4'h4;
			3'h5: periodLog = 4'h6;
			3'h6: periodLog = 4'h7;
			default: periodLog = 4'h9;
			endcase
		end
	endfunction

	reg [3:0] pLog;
	reg [3:0] sLog;
	reg [3:0] capLog;
	always @* begin
		pLog = periodLog(outputDataRate);
		case (oversampleMode)
		`ODB_MODE_NORMAL: capLog = 4'h4;
		`ODB_MODE_LNLP:   capLog = 4'h6;
		`ODB_MODE_HIRES:  capLog = 4'h1;
		default:          capLog = 4'h7;
		endcase
		// step follows the sample period up to the mode's cap
		sLog = (pLog > capLog) ? capLog : pLog;
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			stepIncr <= 8'h01;
			stepUs   <= 18'h0_04E2;
		end else begin
			// a weight of 256 does not fit; saturating still commits
			// on one sample, since no count can exceed 8'hFF
			stepIncr <= ((pLog - sLog) > 4'h7) ? 8'hFF :
			            (8'h01 << (pLog - sLog));
			stepUs   <= {2'b00, `ODB_STEPUS_800} << sLog;
		end
	end
endmodule

// *** odb_orientation_debounce_detector.v ***
// orientation detection with debounce and its register file
// Operation
// - detection runs only while the enable bit 6 is set; reset clears it
// - debounce mode 0: counter decrements per sample once condition drops
// - debounce mode 1 (reset value): counter clears once condition drops
// - writable 8-bit debounce count, reset zero; latency = count x step
// - any wake/sleep power-state change resets the debounce counter
// - step 1.25 ms at 800 Hz, 2.5 ms at 400 Hz; high-res stays 2.5 ms
// - lower rates follow sample period, capped 20/80/160 ms by mode
// - read-only back/front trip code 01 in bits 7:6, about 75 degrees
// - read-only Z-lock code 100 in bits 2:0, 29 degrees, used for lockout
// - read-only trip threshold code 1_0000 in bits 7:3, 45 degrees
// - read-only hysteresis code 100 in bits 2:0, plus/minus 14 degrees
// - landscape to portrait at 59 degrees, portrait to landscape at 31
// - change flag on first detection after active entry or any change
// - hold orientation while any axis magnitude exceeds 1.25g
// - code 00/01 portrait up/down, 10/11 landscape right/left; back=1
`timescale 1ns/1ps
`include "odb_map.vh"
module odb_orientation_debounce_detector (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire [7:0]  regAddr,
	input  wire        regWrEn,
	input  wire [7:0]  regWrData,
	input  wire        regRdEn,
	output reg  [7:0]  regRdData,
	input  wire        sampleTick,
	input  wire [2:0]  outputDataRate,
	input  wire [1:0]  oversampleMode,
	input  wire        activeMode,
	input  wire        wakeState,
	input  wire [6:0]  portraitAngle,
	input  wire        portraitDown,
	input  wire        landscapeLeft,
	input  wire [6:0]  planeElevation,
	input  wire        zNegative,
	input  wire [9:0]  accelX,
	input  wire [9:0]  accelY,
	input  wire [9:0]  accelZ,
	output wire [1:0]  orientationCode,
	output wire        facingBit,
	output wire        tiltLockout,
	output wire        orientationChanged,
	output wire [17:0] stepMicros
);
	reg  [7:0] configReg_r;
	reg  [7:0] dbCount_r;
	reg  [7:0] dbCnt_r;
	reg  [7:0] dbCnt_nxt;
	reg  [1:0] orient_r;
	reg        facing_r;
	reg        lockout_r;
	reg        changed_r;
	reg        firstPend_r;
	reg        active_r;
	reg        wake_r;
	reg        wakeSeen_r;
	reg  [1:0] candOrient;
	reg        candFacing;
	reg        candLockout;
	reg        differs;
	reg        commit;
	reg  [8:0] sum;
	wire [7:0] stepIncr;
	wire       enabled;
	wire       dbClearMode;
	wire       overG;
	wire       statusRead;
	wire       powerFlip;
	wire       tickTaken;
	wire [7:0] statusWord;

	odb_time_step uStep (
		.clk_sys        (clk_sys),
		.rst            (rst),
		.outputDataRate (outputDataRate),
		.oversampleMode (oversampleMode),
		.stepIncr       (stepIncr),
		.stepUs         (stepMicros)
	);

	function [9:0] magOf;
		input [9:0] v;
		begin
			magOf = v[9] ? (~v + 10'h001) : v;
		end
	endfunction

	assign enabled     = configReg_r[`ODB_CFG_ENABLE_BIT];
	assign dbClearMode = configReg_r[`ODB_CFG_DBMODE_BIT];
	assign overG = (magOf(accelX) > `ODB_OVERG_COUNTS) ||
	               (magOf(accelY) > `ODB_OVERG_COUNTS) ||
	               (magOf(accelZ) > `ODB_OVERG_COUNTS);
	assign statusRead = regRdEn && (regAddr == `ODB_ADDR_STATUS);
	// the first look at the power pin after reset is not a change
	assign powerFlip  = wakeSeen_r && (wakeState != wake_r);
	// a sample that the detector actually evaluates
	assign tickTaken  = sampleTick && enabled && !overG && !powerFlip;
	assign statusWord = {changed_r, lockout_r, 3'b000, orient_r, facing_r};
	assign orientationCode    = orient_r;
	assign facingBit          = facing_r;
	assign tiltLockout        = lockout_r;
	assign orientationChanged = changed_r;

	// candidate state from the angle inputs with hysteresis on committed state
	always @* begin
		candLockout = planeElevation < `ODB_ANGLE_A_DEG;
		candFacing  = zNegative &&
		              (planeElevation < `ODB_BACKFRONT_DEG);
		candOrient  = orient_r;
		if (!candLockout) begin
			if (!orient_r[1]) begin
				if (portraitAngle <= `ODB_TRIP_TO_LAND)
					candOrient = {1'b1, landscapeLeft};
				else
					candOrient = {1'b0, portraitDown};
			end else begin
				if (portraitAngle >= `ODB_TRIP_TO_PORT)
					candOrient = {1'b0, portraitDown};
				else
					candOrient = {1'b1, landscapeLeft};
			end
		end
		differs = (candOrient != orient_r) || (candFacing != facing_r) ||
		          (candLockout != lockout_r);
	end

	// debounce counter; a sample may weigh several steps at slow rates
	always @* begin
		dbCnt_nxt = dbCnt_r;
		commit    = 1'b0;
		sum       = {1'b0, dbCnt_r} + {1'b0, stepIncr};
		if (powerFlip || !enabled) begin
			dbCnt_nxt = 8'h00;
		end else if (sampleTick && !overG) begin
			if (differs) begin
				dbCnt_nxt = sum[8] ? 8'hFF : sum[7:0];
				if ((sum[8] || sum[7:0] >= dbCount_r) || firstPend_r) begin
					commit    = 1'b1;
					dbCnt_nxt = 8'h00;
				end
			end else if (dbClearMode) begin
				dbCnt_nxt = 8'h00;
			end else if (dbCnt_r > stepIncr) begin
				dbCnt_nxt = dbCnt_r - stepIncr;
			end else begin
				dbCnt_nxt = 8'h00;
			end
		end
	end

	// host-visible configuration; unused config bits always read zero
	always @(posedge clk_sys) begin
		if (rst) begin
			configReg_r <= `ODB_CFG_RESET;
			dbCount_r   <= `ODB_DBCOUNT_RESET;
		end else begin
			if (regWrEn && regAddr == `ODB_ADDR_CONFIG)
				configReg_r <= regWrData & 8'hC0;
			if (regWrEn && regAddr == `ODB_ADDR_DBCOUNT)
				dbCount_r <= regWrData;
		end
	end

	// debounce counter, committed orientation and pin history
	always @(posedge clk_sys) begin
		if (rst) begin
			dbCnt_r    <= 8'h00;
			orient_r   <= 2'b00;
			facing_r   <= 1'b0;
			lockout_r  <= 1'b0;
			active_r   <= 1'b0;
			wake_r     <= 1'b0;
			wakeSeen_r <= 1'b0;
		end else begin
			active_r   <= activeMode;
			wake_r     <= wakeState;
			wakeSeen_r <= 1'b1;
			dbCnt_r    <= dbCnt_nxt;
			if (commit) begin
				orient_r  <= candOrient;
				facing_r  <= candFacing;
				lockout_r <= candLockout;
			end
		end
	end

	// change flag; a new event in the read cycle wins over the clear
	always @(posedge clk_sys) begin
		if (rst) begin
			changed_r   <= 1'b0;
			firstPend_r <= 1'b0;
		end else begin
			// first detection after entering active must raise the flag
			if (activeMode && !active_r)
				firstPend_r <= 1'b1;
			else if (tickTaken)
				firstPend_r <= 1'b0;
			if (commit || (firstPend_r && tickTaken))
				changed_r <= 1'b1;
			else if (statusRead)
				changed_r <= 1'b0;
		end
	end

	// read port; data is registered and holds until the next read
	always @(posedge clk_sys) begin
		if (rst) begin
			regRdData <= 8'h00;
		end else if (regRdEn) begin
			case (regAddr)
			`ODB_ADDR_STATUS:  regRdData <= statusWord;
			`ODB_ADDR_CONFIG:  regRdData <= configReg_r;
			`ODB_ADDR_DBCOUNT: regRdData <= dbCount_r;
			`ODB_ADDR_BFZLOCK:
				regRdData <= `ODB_BFZLOCK_VALUE;
			`ODB_ADDR_THSHYS:
				regRdData <= `ODB_THSHYS_VALUE;
			default:           regRdData <= 8'h00;
			endcase
		end
	end
endmodule

// *** odb_checker_props.sv ***
// port assertions for the orientation detector
`timescale 1ns/1ps
module odb_checker (
	input wire        clk_sys,
	input wire        rst,
	input wire [7:0]  regAddr,
	input wire        regRdEn,
	input wire [7:0]  regRdData,
	input wire        sampleTick,
	input wire [2:0]  outputDataRate,
	input wire [1:0]  oversampleMode,
	input wire [9:0]  accelX,
	input wire [1:0]  orientationCode,
	input wire        orientationChanged,
	input wire [17:0] stepMicros
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_bfz_fixed: assert property (
		regRdEn && regAddr == 8'h13 |=> regRdData == 8'h44)
		else $error("angle read wrong");
	a_ths_fixed: assert property (
		regRdEn && regAddr == 8'h14 |=> regRdData == 8'h84)
		else $error("threshold read wrong");
	// two cycles of stable input required, though the step passes through only one register stage
	a_step_fast: assert property (
		(outputDataRate == 3'h0) [*2] |=> stepMicros == 18'h4E2)
		else $error("800 Hz step wrong");
	a_step_hires: assert property (
		(oversampleMode == 2'h2 && outputDataRate != 3'h0) [*2]
		|=> stepMicros == 18'h9C4) else $error("hires step wrong");
	a_step_lpcap: assert property (
		(oversampleMode == 2'h3 && outputDataRate > 3'h5) [*2]
		|=> stepMicros == 18'h2_7100) else $error("lp step wrong");
	a_overg_hold: assert property (
		sampleTick && !accelX[9] && accelX > 10'h140
		|=> $stable(orientationCode)) else $error("over-g moved code");
	a_flag_clear: assert property (
		regRdEn && regAddr == 8'h10 && !sampleTick
		|=> !orientationChanged) else $error("flag not cleared");
	a_tick_commit: assert property (
		!$stable(orientationCode) |-> $past(sampleTick))
		else $error("code moved without sample");
endmodule
bind odb_orientation_debounce_detector odb_checker i_odb_checker (.*);

// *** odb_host_model.sv ***
// host side of the register access port
`timescale 1ns/1ps
module odb_host_model (
	input  wire       clk_sys,
	input  wire [7:0] regRdData,
	output reg  [7:0] regAddr,
	output reg        regWrEn,
	output reg  [7:0] regWrData,
	output reg        regRdEn
);
	initial {regAddr, regWrEn, regWrData, regRdEn} = 18'h0_0000;
	task wr(input [7:0] a, input [7:0] d);
		@(negedge clk_sys) {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
		@(negedge clk_sys) regWrEn = 1'b0;
	endtask
	// data is registered, so it is settled one edge after the strobe
	task rd(input [7:0] a, output [7:0] d);
		@(negedge clk_sys) {regAddr, regRdEn} = {a, 1'b1};
		@(negedge clk_sys) regRdEn = 1'b0;
		d = regRdData;
	endtask
endmodule

// *** odb_orientation_debounce_detector_tb_top.sv ***
// self-checking bench for the orientation detector
`timescale 1ns/1ps
`define CK(n, e, v) begin total_checks++; if ((v) !== (e)) begin \
	bad_count++; $display("CHECK FAILED %s exp %h got %h", n, e, v); \
	end end
module odb_orientation_debounce_detector_tb_top;
	reg        clk_sys = 0, rst = 1, sampleTick = 0, activeMode = 0;
	reg        wakeState = 1, portraitDown = 0, landscapeLeft = 0;
	reg        zNegative = 0;
	reg [2:0]  outputDataRate = 0;
	reg [1:0]  oversampleMode = 0;
	reg [6:0]  portraitAngle = 7'h46, planeElevation = 7'h3C;
	reg [9:0]  accelX = 0, accelY = 0, accelZ = 0;
	wire [7:0] regAddr, regWrData, regRdData;
	wire       regWrEn, regRdEn, facingBit, tiltLockout;
	wire       orientationChanged;
	wire [1:0] orientationCode;
	wire [17:0] stepMicros;
	int        bad_count = 0, total_checks = 0, i;
	reg [17:0] stepTab [0:7];
	initial forever #10 clk_sys = ~clk_sys;
	odb_orientation_debounce_detector i_odb_orientation_debounce_detector (.*);
	odb_host_model i_odb_host_model (.*);
	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task tick(input [6:0] a, input int n);
		repeat (n) begin
			@(negedge clk_sys) {portraitAngle, sampleTick} = {a, 1'b1};
			@(negedge clk_sys) sampleTick = 0;
		end
		@(negedge clk_sys);
	endtask
	task pat(input [6:0] a, input [6:0] b);
		tick(a, 2);
		tick(b, 1);
		tick(a, 2);
	endtask
	task w(input [7:0] a, input [7:0] d);
		i_odb_host_model.wr(a, d);
	endtask
	task rc(input [7:0] a, input [7:0] e);
		reg [7:0] d;
		i_odb_host_model.rd(a, d);
		`CK("regRdData", e, d)
	endtask
	initial begin
		repeat (5000) @(posedge clk_sys);
		bad_count++;
		complete_run;
	end
	initial begin
		stepTab = '{18'h4E2, 18'h9C4, 18'h1388, 18'h2710,
			18'h4E20, 18'h4E20, 18'h4E20, 18'h4E20};
		repeat (3) @(negedge clk_sys);
		rst = 0;
		rc(8'h11, 8'h80);
		rc(8'h12, 8'h00);
		w(8'h13, 8'h00);
		w(8'h14, 8'h00);
		rc(8'h13, 8'h44);
		rc(8'h14, 8'h84);
		rc(8'h20, 8'h00);
		$display("register test done");
		portraitDown = 1;
		tick(7'h46, 2);
		`CK("code", 2'b00, orientationCode)
		w(8'h11, 8'hFF);
		w(8'h12, 8'h02);
		rc(8'h12, 8'h02);
		activeMode = 1;
		tick(7'h46, 1);
		rc(8'h10, 8'h82);
		rc(8'h10, 8'h02);
		landscapeLeft = 1;
		tick(7'h14, 1);
		`CK("code", 2'b01, orientationCode)
		tick(7'h14, 1);
		`CK("code", 2'b11, orientationCode)
		tick(7'h2D, 3);
		`CK("code", 2'b11, orientationCode)
		w(8'h12, 8'h03);
		portraitDown = 0;
		pat(7'h46, 7'h14);
		`CK("code", 2'b11, orientationCode)
		w(8'h11, 8'h40);
		tick(7'h46, 1);
		`CK("code", 2'b00, orientationCode)
		pat(7'h14, 7'h46);
		`CK("code", 2'b11, orientationCode)
		tick(7'h46, 2);
		wakeState = 0;
		tick(7'h46, 2);
		`CK("code", 2'b11, orientationCode)
		accelX = 10'h150;
		tick(7'h46, 4);
		`CK("code", 2'b11, orientationCode)
		accelX = 0;
		planeElevation = 7'h14;
		tick(7'h14, 3);
		`CK("lockout", 1'b1, tiltLockout)
		zNegative = 1;
		tick(7'h14, 3);
		`CK("facing", 1'b1, facingBit)
		`CK("changed", 1'b1, orientationChanged)
		rc(8'h10, 8'hC7);
		`CK("changed", 1'b0, orientationChanged)
		$display("detection test done");
		for (i = 0; i < 8; i++) begin
			outputDataRate = i[2:0];
			repeat (3) @(negedge clk_sys);
			`CK("step", stepTab[i], stepMicros)
		end
		oversampleMode = 2'h1;
		repeat (3) @(negedge clk_sys);
		`CK("step", 18'h1_3880, stepMicros)
		oversampleMode = 2'h3;
		repeat (3) @(negedge clk_sys);
		`CK("step", 18'h2_7100, stepMicros)
		oversampleMode = 2'h2;
		repeat (3) @(negedge clk_sys);
		`CK("step", 18'h9C4, stepMicros)
		planeElevation = 7'h3C;
		tick(7'h46, 1);
		`CK("code", 2'b00, orientationCode)
		`CK("lockout", 1'b0, tiltLockout)
		$display("step test done");
		complete_run;
	end
endmodule
